// ===== logic/rsoc_delay.sv
`timescale 1ns/1ps
module rsoc_delay #(
  parameter int unsigned CYC_PER_SEC = rsoc_pkg::CYCLES_PER_SEC
) (
  input  wire logic  i_clock,
  input  wire logic  i_rst_n,
  rsoc_dly_if.unit   dly
);

  localparam int unsigned CW = $clog2(CYC_PER_SEC + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_SEC - 1);

  typedef struct packed {
    rsoc_pkg::rsoc_dly_state_t state;
    logic [CW-1:0]             cyc;
    logic [9:0]                sec;
  } rsoc_dly_st_t;

  rsoc_dly_st_t st_r;
  rsoc_dly_st_t st_nxt;
  logic         sec_done;
  logic [9:0]   sec_inc;

  // Seconds are counted from the moment the wait starts, so a delay is
  // exact to the cycle rather than jittered by a free-running tick.
  always_comb begin
    st_nxt   = st_r;
    sec_done = (st_r.cyc == CYC_LAST);
    sec_inc  = st_r.sec + 10'h001;
    unique case (st_r.state)
      rsoc_pkg::DLY_OFF: begin
        st_nxt.cyc = '0;
        st_nxt.sec = '0;
        if (dly.cond) begin
          st_nxt.state = (dly.on_dly == '0) ? rsoc_pkg::DLY_ON
                                            : rsoc_pkg::DLY_ON_WAIT;
        end
      end
      rsoc_pkg::DLY_ON_WAIT: begin
        if (!dly.cond) begin
          // The timer is cleared here so that a later rise waits in full.
          st_nxt.state = rsoc_pkg::DLY_OFF;
          st_nxt.cyc   = '0;
          st_nxt.sec   = '0;
        end else if (sec_done) begin
          st_nxt.cyc = '0;
          st_nxt.sec = sec_inc;
          if (sec_inc >= dly.on_dly) begin
            st_nxt.state = rsoc_pkg::DLY_ON;
          end
        end else begin
          st_nxt.cyc = st_r.cyc + CW'(1);
        end
      end
      rsoc_pkg::DLY_ON: begin
        st_nxt.cyc = '0;
        st_nxt.sec = '0;
        if (!dly.cond) begin
          st_nxt.state = (dly.off_dly == '0) ? rsoc_pkg::DLY_OFF
                                             : rsoc_pkg::DLY_OFF_WAIT;
        end
      end
      rsoc_pkg::DLY_OFF_WAIT: begin
        if (dly.cond) begin
          st_nxt.state = rsoc_pkg::DLY_ON;
          st_nxt.cyc   = '0;
          st_nxt.sec   = '0;
        end else if (sec_done) begin
          st_nxt.cyc = '0;
          st_nxt.sec = sec_inc;
          if (sec_inc >= dly.off_dly) begin
            st_nxt.state = rsoc_pkg::DLY_OFF;
          end
        end else begin
          st_nxt.cyc = st_r.cyc + CW'(1);
        end
      end
      default: begin
        st_nxt.state = rsoc_pkg::DLY_OFF;
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{state: rsoc_pkg::DLY_OFF, cyc: '0, sec: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // The relay is held while on or while an off-delay is pending.
  assign dly.relay = (st_r.state == rsoc_pkg::DLY_ON) ||
                     (st_r.state == rsoc_pkg::DLY_OFF_WAIT);

  AST_ON_DELAY_HOLDS: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    (st_r.state == rsoc_pkg::DLY_OFF) && dly.cond && (dly.on_dly != '0)
    |=> !dly.relay ##1 !dly.relay)
    else $error("Relay switched on before its on-delay.");

  AST_OFF_DELAY_HOLDS: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    (st_r.state == rsoc_pkg::DLY_ON) && !dly.cond && (dly.off_dly != '0)
    |=> dly.relay)
    else $error("Relay switched off before its off-delay.");

  AST_CANCEL_PENDING: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    (st_r.state == rsoc_pkg::DLY_ON_WAIT) && !dly.cond
    |=> (st_r.state == rsoc_pkg::DLY_OFF) && (st_r.sec == '0))
    else $error("Pending on-delay was not cancelled.");

endmodule // rsoc_delay

// ===== logic/rsoc_dly_if.sv
`timescale 1ns/1ps
interface rsoc_dly_if;
  logic       cond;
  logic [9:0] on_dly;
  logic [9:0] off_dly;
  logic       relay;

  modport ctrl (output cond, output on_dly, output off_dly, input relay);
  modport unit (input cond, input on_dly, input off_dly, output relay);
endinterface

// ===== logic/rsoc_pkg.sv
package rsoc_pkg;

  // Source-select codes and their field width.
  localparam int unsigned SEL_W         = 5;
  localparam logic [4:0]  SRC_NONE      = 5'h00;
  localparam logic [4:0]  SRC_RUNNING   = 5'h03;
  localparam logic [4:0]  SRC_NO_ALARM  = 5'h0a;
  localparam logic [4:0]  SRC_CUR_LIMIT = 5'h0b;
  localparam logic [4:0]  SRC_CTRL_WORD = 5'h1d;
  localparam logic [4:0]  SRC_MOTOR_ALT = 5'h1e;
  localparam logic [4:0]  SRC_MAX       = 5'h1e;
  localparam int unsigned FLAG_W        = 29;

  // Values after reset.
  localparam logic [4:0]  RST_SEL1      = SRC_NO_ALARM;
  localparam logic [4:0]  RST_SEL2      = SRC_RUNNING;
  localparam logic [9:0]  RST_ON_DLY_S  = 10'h000;
  localparam logic [9:0]  RST_OFF_DLY_S = 10'h000;

  // Control-word bit positions that drive the relays.
  localparam int unsigned CW_BIT_RELAY1 = 11;
  localparam int unsigned CW_BIT_RELAY2 = 12;

  // Delay range in seconds.
  localparam int unsigned DLY_W         = 10;
  localparam logic [9:0]  MAX_DLY_S     = 10'h258;

  // Running threshold: 0.1 Hz, in units of 0.1 Hz.
  localparam logic [15:0] RUN_MIN_DHZ   = 16'h0001;

  // Timing: one-second base derived from the clock rate.
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned SEC_BASE_S    = 1;
  localparam int unsigned CYCLES_PER_SEC = SEC_BASE_S * CLK_HZ;

  // Delay-unit states, one-hot.
  typedef enum logic [3:0] {
    DLY_OFF      = 4'b0001,
    DLY_ON_WAIT  = 4'b0010,
    DLY_ON       = 4'b0100,
    DLY_OFF_WAIT = 4'b1000
  } rsoc_dly_state_t;

endpackage

// ===== logic/rsoc_top.sv
// Operation
// - Select codes 0..30 choose relay source.
// - Reset selects: relay one 10, two 3.
// - Relay follows selected condition, relay one after delays.
// - Control-word bits 11/12 drive relays one/two.
// - Bus timeout cuts control-word driven relays.
// - Relay one on-delay 0..600 s, default 0.
// - Relay one off-delay 0..600 s.
// - Code 30 follows internal motor-alternation timer.
// - Running means start command or frequency >0.1 Hz.
// - Current limit means current above its setting.
`timescale 1ns/1ps
module rsoc_top #(
  parameter int unsigned CYC_PER_SEC = rsoc_pkg::CYCLES_PER_SEC
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_cfg_write,
  input  wire logic [4:0]  i_first_relay_source_select,
  input  wire logic [4:0]  i_second_relay_source_select,
  input  wire logic [9:0]  i_first_relay_switch_on_delay,
  input  wire logic [9:0]  i_first_relay_switch_off_delay,
  input  wire logic [28:0] i_status_flags,
  input  wire logic        i_start_cmd,
  input  wire logic [15:0] i_out_freq_dhz,
  input  wire logic [15:0] i_out_current,
  input  wire logic [15:0] i_current_limit,
  input  wire logic [15:0] i_ctrl_word,
  input  wire logic        i_bus_timeout,
  input  wire logic [15:0] i_alt_interval_s,
  output logic             o_relay1,
  output logic             o_relay2,
  output logic             o_alternation,
  output logic [4:0]       o_first_relay_source_select,
  output logic [4:0]       o_second_relay_source_select
);

  localparam int unsigned CW = $clog2(CYC_PER_SEC + 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_SEC - 1);

  typedef struct packed {
    logic [4:0]    sel1;
    logic [4:0]    sel2;
    logic [9:0]    on_dly;
    logic [9:0]    off_dly;
    logic [CW-1:0] div;
    logic [15:0]   alt_sec;
    logic          alt;
    logic          cond1;
    logic          relay1;
    logic          relay2;
  } rsoc_top_st_t;

  rsoc_top_st_t st_r;
  rsoc_top_st_t st_nxt;
  logic [28:0]  flags;
  logic         cut1;
  logic         cut2;

  rsoc_dly_if dly_if ();

  // Picks the condition for one relay from its select code. Codes above
  // the last valid one read as no function.
  function automatic logic rsoc_src_cond(input logic [4:0]  sel,
                                         input logic [28:0] fl,
                                         input logic        cw_bit,
                                         input logic        alt);
    logic res;
    res = 1'b0;
    if (sel == rsoc_pkg::SRC_CTRL_WORD) begin
      res = cw_bit;
    end else if (sel == rsoc_pkg::SRC_MOTOR_ALT) begin
      res = alt;
    end else if (sel < rsoc_pkg::SRC_CTRL_WORD) begin
      res = fl[sel];
    end
    return res;
  endfunction

  // Condition vector indexed by select code; three entries are set here.
  always_comb begin
    flags = i_status_flags;
    flags[rsoc_pkg::SRC_NONE] = 1'b0;
    flags[rsoc_pkg::SRC_RUNNING] = i_start_cmd ||
      (i_out_freq_dhz > rsoc_pkg::RUN_MIN_DHZ);
    flags[rsoc_pkg::SRC_CUR_LIMIT] =
      (i_out_current > i_current_limit);
  end

  // A bus timeout only affects relays that the control word is holding.
  assign cut1 = i_bus_timeout &&
                (st_r.sel1 == rsoc_pkg::SRC_CTRL_WORD);
  assign cut2 = i_bus_timeout &&
                (st_r.sel2 == rsoc_pkg::SRC_CTRL_WORD);

  // Next state: configuration, alternation timer and relay drives.
  always_comb begin
    st_nxt = st_r;
    // Out-of-range values are ignored so a bad write cannot leave an
    // undefined code or a delay longer than the relay can count.
    if (i_cfg_write) begin
      if (i_first_relay_source_select <= rsoc_pkg::SRC_MAX) begin
        st_nxt.sel1 = i_first_relay_source_select;
      end
      if (i_second_relay_source_select <= rsoc_pkg::SRC_MAX) begin
        st_nxt.sel2 = i_second_relay_source_select;
      end
      if (i_first_relay_switch_on_delay <= rsoc_pkg::MAX_DLY_S) begin
        st_nxt.on_dly = i_first_relay_switch_on_delay;
      end
      if (i_first_relay_switch_off_delay <= rsoc_pkg::MAX_DLY_S) begin
        st_nxt.off_dly = i_first_relay_switch_off_delay;
      end
    end
    // Seconds divider and alternation timer; an interval of zero holds.
    if (st_r.div == CYC_LAST) begin
      st_nxt.div = '0;
      if (i_alt_interval_s != '0) begin
        if (st_r.alt_sec + 16'h0001 >= i_alt_interval_s) begin
          st_nxt.alt_sec = '0;
          st_nxt.alt     = ~st_r.alt;
        end else begin
          st_nxt.alt_sec = st_r.alt_sec + 16'h0001;
        end
      end
    end else begin
      st_nxt.div = st_r.div + CW'(1);
    end
    // Relay one goes through the delay unit; the cut bypasses the delay
    // so a lost bus releases the contact at once.
    st_nxt.cond1 = rsoc_src_cond(st_r.sel1, flags,
                                 i_ctrl_word[rsoc_pkg::CW_BIT_RELAY1],
                                 st_r.alt) && !cut1;
    st_nxt.relay1 = dly_if.relay && !cut1;
    st_nxt.relay2 = rsoc_src_cond(st_r.sel2, flags,
                                  i_ctrl_word[rsoc_pkg::CW_BIT_RELAY2],
                                  st_r.alt) && !cut2;
  end

  // State register with documented defaults.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{sel1: rsoc_pkg::RST_SEL1,
                sel2: rsoc_pkg::RST_SEL2,
                on_dly: rsoc_pkg::RST_ON_DLY_S,
                off_dly: rsoc_pkg::RST_OFF_DLY_S,
                div: '0, alt_sec: '0, alt: 1'b0,
                cond1: 1'b0, relay1: 1'b0, relay2: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Delay unit feeds.
  assign dly_if.cond    = st_r.cond1;
  assign dly_if.on_dly  = st_r.on_dly;
  assign dly_if.off_dly = st_r.off_dly;

  rsoc_delay #(
    .CYC_PER_SEC (CYC_PER_SEC)
  ) u_delay (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .dly     (dly_if.unit)
  );

  // Outputs straight from the state register.
  assign o_relay1                     = st_r.relay1;
  assign o_relay2                     = st_r.relay2;
  assign o_alternation                = st_r.alt;
  assign o_first_relay_source_select  = st_r.sel1;
  assign o_second_relay_source_select = st_r.sel2;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  AST_NONE_RELEASED: assert property (
    st_r.sel2 == rsoc_pkg::SRC_NONE |=> !o_relay2)
    else $error("Relay two active with no function selected.");

  AST_BIT12_DRIVES: assert property (
    (st_r.sel2 == rsoc_pkg::SRC_CTRL_WORD) && !i_bus_timeout
    |=> o_relay2 == $past(i_ctrl_word[12]))
    else $error("Relay two does not follow control-word bit 12.");

  AST_BIT11_DRIVES: assert property (
    (st_r.sel1 == rsoc_pkg::SRC_CTRL_WORD) && !i_bus_timeout &&
    (st_r.on_dly == '0) && i_ctrl_word[11] && !i_cfg_write
    ##1 !i_bus_timeout ##1 !i_bus_timeout |=> o_relay1)
    else $error("Relay one does not follow control-word bit 11.");

  AST_TIMEOUT_CUT1: assert property (
    (st_r.sel1 == rsoc_pkg::SRC_CTRL_WORD) && i_bus_timeout |=> !o_relay1)
    else $error("Relay one held by bus during timeout.");

  AST_TIMEOUT_CUT2: assert property (
    (st_r.sel2 == rsoc_pkg::SRC_CTRL_WORD) && i_bus_timeout |=> !o_relay2)
    else $error("Relay two held by bus during timeout.");

  AST_RUNNING: assert property (
    (st_r.sel2 == rsoc_pkg::SRC_RUNNING) &&
    (i_start_cmd || (i_out_freq_dhz > 16'h0001)) |=> o_relay2)
    else $error("Running condition not shown on relay two.");

  AST_CUR_LIMIT: assert property (
    (st_r.sel2 == rsoc_pkg::SRC_CUR_LIMIT) &&
    (i_out_current > i_current_limit) |=> o_relay2)
    else $error("Current-limit condition not shown on relay two.");

  AST_ALTERNATION: assert property (
    st_r.sel2 == rsoc_pkg::SRC_MOTOR_ALT |=> o_relay2 == $past(st_r.alt))
    else $error("Relay two does not follow the alternation timer.");

  AST_FOLLOWS_FLAG: assert property (
    (st_r.sel2 > rsoc_pkg::SRC_NONE) && (st_r.sel2 < 5'h1d)
    |=> o_relay2 == $past(flags[st_r.sel2]))
    else $error("Relay two does not follow its selected condition.");

endmodule // rsoc_top

// ===== tb/rsoc_load_model.sv
`timescale 1ns/1ps
// Stands in for the loads that the two relay contacts switch. Contact
// bounce is not modelled; a contact settles within one clock.
module rsoc_load_model (
  input  wire logic   i_clock,
  input  wire logic   i_rst_n,
  input  wire logic   i_relay1,
  input  wire logic   i_relay2,
  output logic        o_load1_on,
  output logic        o_load2_on,
  output logic [15:0] o_switch_cnt
);
  // Each load follows its contact; relay one transitions are counted so
  // that chatter from a broken delay shows up as extra switching.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_load1_on   <= 1'b0;
      o_load2_on   <= 1'b0;
      o_switch_cnt <= 16'h0000;
    end else begin
      if (o_load1_on != i_relay1) begin
        o_switch_cnt <= o_switch_cnt + 16'h0001;
      end
      o_load1_on <= i_relay1;
      o_load2_on <= i_relay2;
    end
  end
endmodule // rsoc_load_model

// ===== tb/rsoc_tb_top.sv
`timescale 1ns/1ps
module rsoc_tb_top;
  // A short second keeps the delay tests to a few dozen cycles.
  localparam int unsigned CPS   = 4;
  localparam int          LIMIT = 20000;

  logic        i_clock, i_rst_n, cfg_write, start_cmd, bus_to;
  logic [4:0]  sel1, sel2, osel1, osel2;
  logic [9:0]  on_dly, off_dly;
  logic [28:0] flags;
  logic [15:0] freq, cur, lim, cw, alt_s, sw_cnt, cnt0;
  logic        relay1, relay2, alt, load1, load2, a0;
  integer      seed, error_cnt, check_count, n, tg;
  int          cycles = 0;

  `define CHK(nm, e, g) \
    begin check_count++; if ((g) !== (e)) begin \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
      error_cnt++; end end

  rsoc_top #(.CYC_PER_SEC(CPS)) i_dut (
    .i_clock                        (i_clock),
    .i_rst_n                        (i_rst_n),
    .i_cfg_write                    (cfg_write),
    .i_first_relay_source_select    (sel1),
    .i_second_relay_source_select   (sel2),
    .i_first_relay_switch_on_delay  (on_dly),
    .i_first_relay_switch_off_delay (off_dly),
    .i_status_flags                 (flags),
    .i_start_cmd                    (start_cmd),
    .i_out_freq_dhz                 (freq),
    .i_out_current                  (cur),
    .i_current_limit                (lim),
    .i_ctrl_word                    (cw),
    .i_bus_timeout                  (bus_to),
    .i_alt_interval_s               (alt_s),
    .o_relay1                       (relay1),
    .o_relay2                       (relay2),
    .o_alternation                  (alt),
    .o_first_relay_source_select    (osel1),
    .o_second_relay_source_select   (osel2)
  );

  rsoc_load_model i_load (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_relay1     (relay1),
    .i_relay2     (relay2),
    .o_load1_on   (load1),
    .o_load2_on   (load2),
    .o_switch_cnt (sw_cnt)
  );

  // Free-running bench clock.
  initial i_clock = 1'b0;
  always #20 i_clock = ~i_clock;

  // Expected relay level for a select code; the control-word bit is the
  // one that belongs to the relay under test.
  function automatic logic exp_cond(input logic [4:0] c, input logic cwb);
    case (c)
      5'h00:   exp_cond = 1'b0;
      5'h03:   exp_cond = start_cmd || (freq > 16'h0001);
      5'h0b:   exp_cond = cur > lim;
      5'h1d:   exp_cond = cwb && !bus_to;
      5'h1e:   exp_cond = alt;
      default: exp_cond = flags[c];
    endcase
  endfunction

  // Waits k rising edges and returns at the falling edge after them.
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clock);
    @(negedge i_clock);
  endtask

  // One configuration write; caller is at a falling edge.
  task automatic cfg(input logic [4:0] s1, input logic [4:0] s2,
                     input logic [9:0] on, input logic [9:0] off);
    sel1      = s1;
    sel2      = s2;
    on_dly    = on;
    off_dly   = off;
    cfg_write = 1'b1;
    cyc(1);
    cfg_write = 1'b0;
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles > LIMIT) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    seed = 59776; error_cnt = 0; check_count = 0; i_rst_n = 1'b0;
    cfg_write = 1'b0; sel1 = 5'h00; sel2 = 5'h00; on_dly = 10'h000;
    off_dly = 10'h000; flags = '0; start_cmd = 1'b0; freq = 16'h0000;
    cur = 16'h0000; lim = 16'h0000; cw = 16'h0000; bus_to = 1'b0;
    alt_s = 16'h0000;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    i_rst_n = 1'b1;
    `CHK("sel1 reset", 5'h0a, osel1)
    `CHK("sel2 reset", 5'h03, osel2)
    `CHK("relay1 reset", 1'b0, relay1)
    // Every code on both relays, random conditions, then flags, control word, start command and current inverted.
    for (n = 0; n <= 30; n++) begin
      flags = 29'($random(seed));
      cw = 16'($random(seed));
      start_cmd = 1'($random(seed));
      freq = 16'($random(seed)) & 16'h0003;
      cur = 16'($random(seed));
      lim = 16'($random(seed));
      cfg(n[4:0], n[4:0], 10'h000, 10'h000);
      cyc(3);
      `CHK("relay1 code", exp_cond(n[4:0], cw[11]), relay1)
      `CHK("relay2 code", exp_cond(n[4:0], cw[12]), relay2)
      flags = ~flags; cw = ~cw; start_cmd = ~start_cmd; cur = ~cur;
      cyc(3);
      `CHK("relay1 inv", exp_cond(n[4:0], cw[11]), relay1)
      `CHK("relay2 inv", exp_cond(n[4:0], cw[12]), relay2)
    end
    // Thresholds exactly at the boundary, then one step above.
    cfg(5'h03, 5'h0b, 10'h000, 10'h000);
    start_cmd = 1'b0; freq = 16'h0001; cur = 16'h0100; lim = 16'h0100;
    cyc(3);
    `CHK("running at 0.1", 1'b0, relay1)
    `CHK("current equal", 1'b0, relay2)
    freq = 16'h0002; cur = 16'h0101;
    cyc(3);
    `CHK("running above", 1'b1, relay1)
    `CHK("current above", 1'b1, relay2)
    // An out-of-range code is dropped while the other field loads.
    cfg(5'h1f, 5'h1e, 10'h000, 10'h000);
    `CHK("sel1 kept", 5'h03, osel1)
    `CHK("sel2 loaded", 5'h1e, osel2)
    // Control word drives both relays; bus timeout cuts them.
    cw = 16'h0000;
    // One idle edge keeps the write strobe from being lowered and raised
    // again in the same time step.
    cyc(1);
    cfg(5'h1d, 5'h1d, 10'h000, 10'h000);
    cw = 16'h1800;
    cyc(1);
    `CHK("cw relay2", 1'b1, relay2)
    cyc(2);
    `CHK("cw relay1", 1'b1, relay1)
    bus_to = 1'b1;
    cyc(1);
    `CHK("timeout relay1", 1'b0, relay1)
    `CHK("timeout relay2", 1'b0, relay2)
    bus_to = 1'b0;
    cyc(1);
    `CHK("timeout gone", 1'b1, relay2)
    // On-delay 2 s and off-delay 1 s on relay one.
    cw = 16'h0000;
    cfg(5'h1d, 5'h00, 10'h002, 10'h001);
    // Relay one is still on here and must run out its new off-delay first.
    cyc(3 + 2 * CPS);
    `CHK("idle before on", 1'b0, relay1)
    cnt0 = sw_cnt;
    cw = 16'h0800;
    cyc(1 + 2 * CPS + 1);
    `CHK("on wait", 1'b0, relay1)
    cyc(1);
    `CHK("on done", 1'b1, relay1)
    cw = 16'h0000;
    cyc(2 + CPS);
    `CHK("off wait", 1'b1, relay1)
    cyc(1);
    `CHK("off done", 1'b0, relay1)
    cyc(1);
    `CHK("load switches", cnt0 + 16'h0002, sw_cnt)
    // A short pulse is cancelled and the next rise waits in full.
    cw = 16'h0800;
    cyc(6);
    cw = 16'h0000;
    cyc(12);
    `CHK("cancelled", 1'b0, relay1)
    cw = 16'h0800;
    cyc(2 * CPS + 2);
    `CHK("restart wait", 1'b0, relay1)
    cyc(1);
    `CHK("restart done", 1'b1, relay1)
    // The load lags its contact by one clock.
    cyc(1);
    `CHK("load follows", 1'b1, load1)
    // Alternation timer with a 1 s half-period drives relay two.
    cfg(5'h1e, 5'h1e, 10'h000, 10'h000);
    alt_s = 16'h0001;
    tg = 0;
    for (n = 0; n < 10 * CPS; n++) begin
      a0 = alt;
      cyc(1);
      if (alt !== a0) tg++;
      `CHK("alt relay2", a0, relay2)
    end
    `CHK("alt toggles", 10, tg)
    stop_test();
  end
endmodule // rsoc_tb_top
